// >>> rtl/rces_err_latch.sv
// error flags and single errored-descriptor capture
`timescale 1ns/1ns
module rces_err_latch #(
  parameter bit SG_PRESENT = 1'b1
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       soft_reset_i,
  rces_evt_if.status      evt,
  output logic [31:0]     err_desc_o
);
  logic        slv_reg;
  logic        dec_reg;
  logic        latched_reg;
  logic [31:0] desc_reg;
  wire         clr_w = !rst_n_i || soft_reset_i;
  wire         new_err_w = SG_PRESENT && (evt.slv_err || evt.dec_err);

  always_ff @(posedge clk_sys_i) begin
    if (clr_w) begin
      slv_reg     <= 1'b0;
      dec_reg     <= 1'b0;
      latched_reg <= 1'b0;
      desc_reg    <= rces_pkg::ZERO_WORD;
    end else begin
      if (SG_PRESENT && evt.slv_err) slv_reg <= 1'b1;
      if (SG_PRESENT && evt.dec_err) dec_reg <= 1'b1;
      if (new_err_w && !latched_reg) begin
        desc_reg    <= evt.err_desc;
        latched_reg <= 1'b1;
      end
    end
  end

  assign evt.flag_slv = slv_reg;
  assign evt.flag_dec = dec_reg;
  assign evt.latched  = latched_reg;
  assign evt.any_err  = slv_reg || dec_reg;
  assign err_desc_o   = desc_reg;

  a_desc_held_once: assert property (@(posedge clk_sys_i) disable iff (clr_w)
    latched_reg && new_err_w |=> $stable(desc_reg))
    else $error("errored descriptor overwritten");
  a_flags_sticky: assert property (@(posedge clk_sys_i) disable iff (clr_w)
    slv_reg |=> slv_reg)
    else $error("slave error flag dropped without reset");
endmodule : rces_err_latch

// >>> rtl/rces_evt_if.sv
// interface: error and completion events from the channel engine to the status logic
`timescale 1ns/1ns
interface rces_evt_if;
  logic        slv_err;
  logic        dec_err;
  logic        ioc_evt;
  logic [31:0] err_desc;
  logic        any_err;
  logic        flag_slv;
  logic        flag_dec;
  logic        latched;
  modport engine (output slv_err, output dec_err, output ioc_evt, output err_desc,
                  input any_err);
  modport status (input slv_err, input dec_err, input ioc_evt, input err_desc,
                  output any_err, output flag_slv, output flag_dec, output latched);
endinterface : rces_evt_if

// >>> rtl/rces_pkg.sv
// package: register map, field positions and reset values of the read channel status block
package rces_pkg;
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_CUR_DESC   = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'hC;
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_SRST_BIT   = 2;
  localparam int          CTRL_IOC_EN_BIT = 12;
  localparam int          CTRL_THR_LSB    = 16;
  localparam int          ST_HALTED_BIT   = 0;
  localparam int          ST_SLV_ERR_BIT  = 9;
  localparam int          ST_DEC_ERR_BIT  = 10;
  localparam int          ST_RSVD_BIT     = 11;
  localparam int          ST_IOC_BIT      = 12;
  localparam int          ST_THR_LSB      = 16;
  localparam logic [7:0]  THRESHOLD_RESET = 8'h01;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RESET  = 32'h0000_1000;
endpackage : rces_pkg

// >>> rtl/rces_status.sv
// read channel error and completion status block with register port
`timescale 1ns/1ns
module rces_status #(
  parameter bit SG_PRESENT = 1'b1
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        desc_slv_err_i,
  input  wire logic        desc_dec_err_i,
  input  wire logic [31:0] err_desc_addr_i,
  input  wire logic        desc_done_i,
  input  wire logic        desc_eof_i,
  input  wire logic        xfer_done_i,
  input  wire logic        engine_idle_i,
  output logic             run_stop_o,
  output logic             halted_o,
  output logic             irq_o
);
  typedef enum logic [2:0] {
    RCES_ST_RUN  = 3'b001,
    RCES_ST_STOP = 3'b010,
    RCES_ST_HALT = 3'b100
  } rces_state_e;

  rces_state_e state_reg;
  rces_state_e state_next;
  logic        run_reg;
  logic        soft_rst_reg;
  logic        ioc_en_reg;
  logic [7:0]  thr_reg;
  logic [7:0]  thr_cnt_reg;
  logic        ioc_reg;
  logic [31:0] mask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] err_desc_w;

  rces_evt_if evt ();
  assign evt.slv_err  = desc_slv_err_i;
  assign evt.dec_err  = desc_dec_err_i;
  assign evt.err_desc = err_desc_addr_i;

  rces_err_latch #(.SG_PRESENT(SG_PRESENT)) u_err (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .soft_reset_i (soft_rst_reg),
    .evt          (evt.status),
    .err_desc_o   (err_desc_w)
  );

  wire sel_ctrl_w  = (reg_addr_i == rces_pkg::ADDR_CONTROL);
  wire sel_stat_w  = (reg_addr_i == rces_pkg::ADDR_STATUS);
  wire sel_desc_w  = (reg_addr_i == rces_pkg::ADDR_CUR_DESC);
  wire sel_mask_w  = (reg_addr_i == rces_pkg::ADDR_IRQ_MASK);
  wire addr_hit_w  = sel_ctrl_w || sel_stat_w || sel_desc_w || sel_mask_w;
  wire wr_ctrl_w   = reg_wr_i && sel_ctrl_w;
  wire wr_stat_w   = reg_wr_i && sel_stat_w;
  wire wr_mask_w   = reg_wr_i && sel_mask_w;
  wire err_now_w   = SG_PRESENT && (desc_slv_err_i || desc_dec_err_i);
  wire ioc_evt_w   = SG_PRESENT ? (desc_done_i && desc_eof_i) : xfer_done_i;
  wire ioc_clr_w   = wr_stat_w && reg_wdata_i[rces_pkg::ST_IOC_BIT];
  wire thr_met_w   = (thr_cnt_reg >= thr_reg);
  wire [7:0] cnt_inc_w = (thr_cnt_reg == 8'hFF) ? 8'hFF : thr_cnt_reg + 8'h01;
  wire halted_w    = (state_reg == RCES_ST_HALT);
  wire err_bit_s_w = SG_PRESENT && evt.flag_slv;
  wire err_bit_d_w = SG_PRESENT && evt.flag_dec;

  // status word; bit 11 is hardwired low
  wire [31:0] status_w = {8'h00, thr_cnt_reg, 3'b000, ioc_reg, 1'b0,
                          err_bit_d_w, err_bit_s_w, 8'h00, halted_w};
  wire [31:0] ctrl_w   = {8'h00, thr_reg, 3'b000, ioc_en_reg, 11'h000, run_reg};
  wire [31:0] rdata_w  = sel_ctrl_w ? ctrl_w :
                         sel_stat_w ? status_w :
                         sel_desc_w ? err_desc_w :
                         sel_mask_w ? mask_reg :
                         rces_pkg::ZERO_WORD;

  // halt sequence: run/stop drops at once, halted waits for the engine to go idle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RCES_ST_RUN:  if (err_now_w || (wr_ctrl_w && !reg_wdata_i[rces_pkg::CTRL_RUN_BIT]))
                      state_next = RCES_ST_STOP;
      RCES_ST_STOP: if (engine_idle_i) state_next = RCES_ST_HALT;
      RCES_ST_HALT: if (wr_ctrl_w && reg_wdata_i[rces_pkg::CTRL_RUN_BIT] && !evt.any_err)
                      state_next = RCES_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || soft_rst_reg) begin
      state_reg <= RCES_ST_HALT;
      run_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (err_now_w || evt.any_err) run_reg <= 1'b0;
      else if (wr_ctrl_w) run_reg <= reg_wdata_i[rces_pkg::CTRL_RUN_BIT];
    end
  end

  // soft reset: bit 2 of control, one cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) soft_rst_reg <= 1'b0;
    else soft_rst_reg <= wr_ctrl_w && reg_wdata_i[rces_pkg::CTRL_SRST_BIT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || soft_rst_reg) begin
      ioc_en_reg <= 1'b0;
      thr_reg    <= rces_pkg::THRESHOLD_RESET;
      mask_reg   <= rces_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl_w) begin
        ioc_en_reg <= reg_wdata_i[rces_pkg::CTRL_IOC_EN_BIT];
        thr_reg    <= reg_wdata_i[rces_pkg::CTRL_THR_LSB +: 8];
      end
      if (wr_mask_w) mask_reg <= reg_wdata_i;
    end
  end

  // a new completion wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || soft_rst_reg) ioc_reg <= 1'b0;
    else if (ioc_evt_w) ioc_reg <= 1'b1;
    else if (ioc_clr_w) ioc_reg <= 1'b0;
  end

  // saturating count, so a long burst never wraps below the threshold
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || soft_rst_reg) thr_cnt_reg <= 8'h00;
    else if (ioc_evt_w) thr_cnt_reg <= cnt_inc_w;
    else if (ioc_clr_w) thr_cnt_reg <= 8'h00;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) rdata_reg <= rces_pkg::ZERO_WORD;
    else if (reg_rd_i) rdata_reg <= rdata_w;
    else rdata_reg <= rces_pkg::ZERO_WORD;
  end

  assign reg_rdata_o = rdata_reg;
  assign run_stop_o  = run_reg;
  assign halted_o    = halted_w;
  assign irq_o       = ioc_reg && ioc_en_reg && thr_met_w
                       && mask_reg[rces_pkg::ST_IOC_BIT];

  sequence s_err_seen;
    err_now_w;
  endsequence
  sequence s_stop_then_idle;
    !halted_w ##1 engine_idle_i;
  endsequence

  a_run_drops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_err_seen |=> !run_reg)
    else $error("run/stop not cleared on error");
  a_halt_waits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == RCES_ST_STOP) && !engine_idle_i |=> !halted_w)
    else $error("halted before engine idle");
  a_halt_after_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    (state_reg == RCES_ST_STOP) ##0 s_stop_then_idle |=> halted_w)
    else $error("halted missing after idle");
  a_slv_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    SG_PRESENT && desc_slv_err_i |=> status_w[rces_pkg::ST_SLV_ERR_BIT])
    else $error("slave error bit not set");
  a_dec_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    SG_PRESENT && desc_dec_err_i |=> status_w[rces_pkg::ST_DEC_ERR_BIT])
    else $error("decode error bit not set");
  a_simple_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !SG_PRESENT |-> status_w[rces_pkg::ST_DEC_ERR_BIT:rces_pkg::ST_SLV_ERR_BIT] == 2'b00)
    else $error("error bits set in simple mode");
  a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $past(reg_rd_i) && $past(reg_addr_i) == rces_pkg::ADDR_STATUS
    |-> !reg_rdata_o[rces_pkg::ST_RSVD_BIT])
    else $error("reserved bit read as one");
  a_ioc_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    ioc_evt_w |=> ioc_reg)
    else $error("completion flag not set");
  a_ioc_w1c: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    ioc_clr_w && !ioc_evt_w |=> !ioc_reg)
    else $error("completion flag not cleared by write one");
  a_ioc_w0_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    ioc_reg && wr_stat_w && !reg_wdata_i[rces_pkg::ST_IOC_BIT] |=> ioc_reg)
    else $error("completion flag lost on write zero");
  a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    irq_o |-> ioc_reg && ioc_en_reg && (thr_cnt_reg >= thr_reg))
    else $error("interrupt without flag, enable and threshold");
  a_desc_loaded: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || soft_rst_reg)
    err_now_w && !evt.latched |=> err_desc_w == $past(err_desc_addr_i))
    else $error("errored descriptor not captured");

  sequence s_w1c_write;
    ioc_clr_w && !ioc_evt_w;
  endsequence
  sequence s_clean_run_write;
    halted_w && !evt.any_err && !err_now_w ##0 wr_ctrl_w && reg_wdata_i[rces_pkg::CTRL_RUN_BIT];
  endsequence

  a_err_to_stop: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    (state_reg == RCES_ST_RUN) && err_now_w |=> state_reg == RCES_ST_STOP)
    else $error("error did not start the halt sequence");
  a_err_no_run: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) evt.any_err |-> !run_reg)
    else $error("run/stop set while an error flag stands");
  a_halt_err_stays: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) halted_w && evt.any_err |=> halted_w)
    else $error("left halt while an error flag stands");
  a_halt_stays: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) halted_w && !wr_ctrl_w |=> halted_w)
    else $error("halted dropped without a control write");
  a_run_needs_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) !run_reg && !wr_ctrl_w |=> !run_reg)
    else $error("run/stop rose without a control write");
  a_clean_restart: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) s_clean_run_write |=> run_reg && !halted_w)
    else $error("clean restart refused");
  a_no_self_slv: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    !evt.flag_slv && !(SG_PRESENT && desc_slv_err_i) |=> !evt.flag_slv)
    else $error("slave error flag set without an error");
  a_no_self_dec: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    !evt.flag_dec && !(SG_PRESENT && desc_dec_err_i) |=> !evt.flag_dec)
    else $error("decode error flag set without an error");
  a_dec_flag_kept: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) evt.flag_dec |=> evt.flag_dec)
    else $error("decode error flag dropped without reset");
  a_latched_has_err: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) evt.latched |-> evt.any_err)
    else $error("descriptor captured with no error flag");
  a_desc_stable: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) !err_now_w |=> $stable(err_desc_w))
    else $error("errored descriptor changed without an error");
  a_simple_no_latch: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) !SG_PRESENT |-> !evt.latched)
    else $error("descriptor captured in simple mode");
  a_ioc_quiet: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) !ioc_reg && !ioc_evt_w |=> !ioc_reg)
    else $error("completion flag set without an event");
  a_ioc_simple: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) !SG_PRESENT && xfer_done_i |=> ioc_reg)
    else $error("simple transfer end did not set the flag");
  a_ioc_sg_eof: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    SG_PRESENT && desc_done_i && !desc_eof_i && !ioc_reg |=> !ioc_reg)
    else $error("completion flag set without frame end");
  a_irq_ready: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    ioc_reg && ioc_en_reg && thr_met_w && mask_reg[rces_pkg::ST_IOC_BIT] |-> irq_o)
    else $error("interrupt missing with all conditions met");
  a_mask_gate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) !mask_reg[rces_pkg::ST_IOC_BIT] |-> !irq_o)
    else $error("interrupt while masked");
  a_ioc_en_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    wr_ctrl_w |=> ioc_en_reg == $past(reg_wdata_i[rces_pkg::CTRL_IOC_EN_BIT]))
    else $error("completion enable not written");
  a_thr_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    wr_ctrl_w |=> thr_reg == $past(reg_wdata_i[rces_pkg::CTRL_THR_LSB +: 8]))
    else $error("threshold not written");
  a_cnt_counts: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    ioc_evt_w && thr_cnt_reg != 8'hFF |=> thr_cnt_reg == $past(thr_cnt_reg) + 8'h01)
    else $error("completion count did not step");
  a_cnt_sat: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    thr_cnt_reg == 8'hFF && (ioc_evt_w || !ioc_clr_w) |=> thr_cnt_reg == 8'hFF)
    else $error("completion count wrapped");
  a_cnt_clears: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) s_w1c_write |=> thr_cnt_reg == 8'h00)
    else $error("completion count kept after clear");
  a_ctrl_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) reg_rd_i && sel_ctrl_w |=> reg_rdata_o == $past(ctrl_w))
    else $error("control read data wrong");
  a_mask_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg) reg_rd_i && sel_mask_w |=> reg_rdata_o == $past(mask_reg))
    else $error("mask read data wrong");
  a_desc_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    reg_rd_i && sel_desc_w |=> reg_rdata_o == $past(err_desc_w))
    else $error("descriptor pointer read data wrong");
  a_status_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || soft_rst_reg)
    reg_rd_i && sel_stat_w |=> reg_rdata_o == $past(status_w))
    else $error("status read data wrong");
  a_unmapped_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) reg_rd_i && !addr_hit_w |=> reg_rdata_o == rces_pkg::ZERO_WORD)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) !reg_rd_i |=> reg_rdata_o == rces_pkg::ZERO_WORD)
    else $error("read data outside the read cycle");
endmodule : rces_status

// >>> test/rces_mm_slave.sv
// partner model: descriptor fetch bus slave answering okay, okay with frame end, or an error
`timescale 1ns/1ns
module rces_mm_slave #(
  parameter int LAT = 3
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        fetch_i,
  input  wire logic [1:0]  resp_i,
  input  wire logic [31:0] addr_i,
  output logic             slv_err_o,
  output logic             dec_err_o,
  output logic             done_o,
  output logic             eof_o,
  output logic [31:0]      addr_o,
  output logic             idle_o
);
  // resp: 0 okay, 1 slave error, 2 decode error, 3 okay with frame end
  logic [3:0]  cnt_reg, stop_reg;
  logic [1:0]  resp_reg;
  logic [31:0] addr_reg;
  logic        fire;
  assign fire      = cnt_reg == 4'h1;
  assign slv_err_o = fire && resp_reg == 2'h1;
  assign dec_err_o = fire && resp_reg == 2'h2;
  assign done_o    = fire && resp_reg[0] == resp_reg[1];
  // lines between answers carry the inverse of the last value
  assign eof_o     = fire ? resp_reg[0] : ~resp_reg[0];
  assign addr_o    = fire ? addr_reg : ~addr_reg;
  // engine counts as shut down LAT cycles after run/stop falls
  assign idle_o    = stop_reg == 4'h0;
  always_ff @(posedge clk_sys_i) begin
    if (fetch_i) begin
      resp_reg <= resp_i;
      addr_reg <= addr_i;
    end
    cnt_reg  <= !rst_n_i ? 4'h0 : fetch_i ? 4'(LAT) : cnt_reg - {3'h0, cnt_reg != 4'h0};
    stop_reg <= !rst_n_i ? 4'h0 : run_i ? 4'(LAT) : stop_reg - {3'h0, stop_reg != 4'h0};
  end
endmodule // rces_mm_slave

// >>> test/rces_status_tb.sv
// testbench: register, error and completion checks of the read channel status block
`timescale 1ns/1ns
module rces_status_tb;
  localparam int         LAT = 3;
  localparam logic [3:0] ACT = rces_pkg::ADDR_CONTROL;
  localparam logic [3:0] AST = rces_pkg::ADDR_STATUS;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, fetch = 1'b0;
  logic [1:0]  resp = 2'h0;
  logic [3:0]  ra = 4'h0;
  logic [31:0] wd = 32'h0, fa = 32'h0, d, d0, rdat, rdat0, ea;
  logic        slv, dec, done, eof, idle, run, halt, irq, run0, halt0, irq0;
  int          n_errors = 0;
  int          checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  rces_mm_slave #(.LAT(LAT)) rces_mm_slave_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .run_i(run), .fetch_i(fetch), .resp_i(resp), .addr_i(fa), .slv_err_o(slv),
    .dec_err_o(dec), .done_o(done), .eof_o(eof), .addr_o(ea), .idle_o(idle));
  rces_status #(.SG_PRESENT(1'b1)) rces_status_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .desc_slv_err_i(slv), .desc_dec_err_i(dec), .err_desc_addr_i(ea),
    .desc_done_i(done), .desc_eof_i(eof), .xfer_done_i(1'b0), .engine_idle_i(idle),
    .run_stop_o(run), .halted_o(halt), .irq_o(irq));
  // simple-mode twin on the same bus and events
  rces_status #(.SG_PRESENT(1'b0)) rces_status_simple_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat0), .desc_slv_err_i(slv), .desc_dec_err_i(dec), .err_desc_addr_i(ea),
    .desc_done_i(done), .desc_eof_i(eof), .xfer_done_i(done), .engine_idle_i(idle),
    .run_stop_o(run0), .halted_o(halt0), .irq_o(irq0));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one register write (w=1) or read (w=0); read data land in d and d0
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    wr <= w;
    rd <= !w;
    ra <= a;
    wd <= v;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_sys_i);
    d = rdat;
    d0 = rdat0;
  endtask
  // one descriptor fetch; returns in the cycle after the answer was taken
  task automatic ev(input logic [1:0] r, input logic [31:0] a);
    @(posedge clk_sys_i);
    fetch <= 1'b1;
    resp <= r;
    fa <= a;
    @(posedge clk_sys_i);
    fetch <= 1'b0;
    repeat (LAT) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    acc(1'b0, AST, 32'h0);
    chk("status", 32'h0000_0001, d);
    acc(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0000_0000, d);
    acc(1'b0, rces_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("mask", 32'h0000_1000, d);
    acc(1'b1, ACT, 32'h0001_1001);
    ev(2'h0, 32'h0000_0100);
    acc(1'b0, AST, 32'h0);
    chk("ioc no eof", 32'h0, 32'(d[12]));
    chk("simple ioc", 32'h1, 32'(d0[12]));
    ev(2'h3, 32'h0000_0140);
    acc(1'b0, AST, 32'h0);
    chk("ioc eof", 32'h1, 32'(d[12]));
    chk("irq", 32'h1, 32'(irq));
    acc(1'b1, AST, 32'h0000_0000);
    acc(1'b0, AST, 32'h0);
    chk("ioc kept", 32'h1, 32'(d[12]));
    acc(1'b1, AST, 32'h0000_1800);
    acc(1'b0, AST, 32'h0);
    chk("ioc rsvd", 32'h0, 32'(d[12:11]));
    chk("irq off", 32'h0, 32'(irq));
    acc(1'b1, ACT, 32'h0002_1001);
    ev(2'h3, 32'h0000_0180);
    chk("irq below", 32'h0, 32'(irq));
    ev(2'h3, 32'h0000_01C0);
    chk("irq met", 32'h1, 32'(irq));
    ev(2'h1, 32'h0000_1040);
    chk("run err", 32'h0, 32'(run));
    chk("halt early", 32'h0, 32'(halt));
    ev(2'h2, 32'h0000_2080);
    acc(1'b0, AST, 32'h0);
    chk("err flags", 32'h0000_0601, d & 32'h0000_0E01);
    chk("simple err", 32'h0, 32'(d0[10:9]));
    chk("halted pin", 32'h1, 32'(halt));
    acc(1'b0, rces_pkg::ADDR_CUR_DESC, 32'h0);
    chk("err desc", 32'h0000_1040, d);
    acc(1'b1, AST, 32'hFFFF_FFFF);
    acc(1'b1, ACT, 32'h0000_1001);
    chk("run refused", 32'h0, 32'(run));
    acc(1'b0, AST, 32'h0);
    chk("sticky", 32'h0000_0601, d);
    acc(1'b1, ACT, 32'h0000_0004);
    @(posedge clk_sys_i);
    acc(1'b0, AST, 32'h0);
    chk("soft reset", 32'h0000_0001, d);
    end_of_test;
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_errors++;
    end_of_test;
  end
endmodule // rces_status_tb
